// ### logic/station_control.sv
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module station_control #(
  parameter int FAST_CYC = station_pkg::FAST_CYCLES,
  parameter int SLOW_CYC = station_pkg::SLOW_CYCLES,
  parameter int FEED_CYC = station_pkg::FEED_CYCLES
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // host output channel
  input wire logic [station_pkg::CHAR_W-1:0] host_out_data_i,
  input wire logic host_out_valid_i,
  output logic host_out_ack_o,
  output logic host_busy_o,
  // host input channel
  output logic [station_pkg::CHAR_W-1:0] host_in_data_o,
  output logic host_in_valid_o,
  input wire logic host_ready_busy_i,
  // keyboard pins
  input wire logic [station_pkg::CHAR_W-1:0] kbd_data_i,
  input wire logic kbd_strobe_i,
  output logic kbd_lock_o,
  // printer pins
  output logic [station_pkg::CHAR_W-1:0] prn_data_o,
  output logic prn_strobe_o,
  input wire logic prn_return_i,
  // card unit pins
  input wire logic [station_pkg::CHAR_W-1:0] card_data_i,
  input wire logic card_strobe_i,
  input wire logic card_skip_i,
  input wire logic card_punch_busy_i,
  input wire logic card_empty_i,
  output logic [station_pkg::CHAR_W-1:0] punch_data_o,
  output logic punch_strobe_o,
  output logic [1:0] card_mode_o,
  output logic alarm_o
);
  import station_pkg::*;

  // pin synchronisers: stage one feeds stage two only
  logic [CHAR_W-1:0] kbd_d1_reg, kbd_d2_reg, card_d1_reg, card_d2_reg;
  logic [5:0] pin1_reg, pin2_reg;
  logic kbd_prev_reg, card_prev_reg, skip_prev_reg;
  logic kbd_edge, card_edge, skip_edge;
  logic ret_s, punch_busy_s, empty_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kbd_d1_reg <= '0;
      kbd_d2_reg <= '0;
      card_d1_reg <= '0;
      card_d2_reg <= '0;
      pin1_reg <= '0;
      pin2_reg <= '0;
    end else if (ce_i) begin
      kbd_d1_reg <= kbd_data_i;
      kbd_d2_reg <= kbd_d1_reg;
      card_d1_reg <= card_data_i;
      card_d2_reg <= card_d1_reg;
      pin1_reg <= {card_empty_i, card_punch_busy_i, prn_return_i,
                   card_skip_i, card_strobe_i, kbd_strobe_i};
      pin2_reg <= pin1_reg;
    end
  end

  // edge detection on the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kbd_prev_reg <= 1'b0;
      card_prev_reg <= 1'b0;
      skip_prev_reg <= 1'b0;
    end else if (ce_i) begin
      kbd_prev_reg <= pin2_reg[0];
      card_prev_reg <= pin2_reg[1];
      skip_prev_reg <= pin2_reg[2];
    end
  end

  assign kbd_edge = pin2_reg[0] && !kbd_prev_reg;
  assign card_edge = pin2_reg[1] && !card_prev_reg;
  assign skip_edge = pin2_reg[2] && !skip_prev_reg;
  assign ret_s = pin2_reg[3];
  assign punch_busy_s = pin2_reg[4];
  assign empty_s = pin2_reg[5];

  // control register and mode decode
  logic [4:0] ctrl_reg;
  logic [31:0] count_reg;
  mode_t f;
  logic on, card_active, bidir;
  logic to_host, from_host;

  assign on = ctrl_reg[CTRL_EN_BIT];
  assign f = on ? decode_mode(ctrl_reg[CTRL_MODE_LSB +: 4]) : '0;
  assign card_active = f.rd || f.punch;
  assign bidir = on && !card_active && (f.kbd || f.from_host);
  assign to_host = f.to_host || bidir;
  assign from_host = f.from_host || bidir;

  // forwarding state
  seq_t seq_reg;
  logic kbd_pend_reg, card_pend_reg;
  logic [CHAR_W-1:0] kbd_char_reg, card_char_reg;
  logic [6:0] ccol_reg, pcol_reg;
  logic [TIMER_W-1:0] feed_reg;
  logic feed_on, out_empty, stall, pace_ok, pace_start;
  logic take_host, take_card, take_kbd, take_any, card_wrap;
  logic [CHAR_W-1:0] ch;
  logic [TIMER_W-1:0] interval;

  assign feed_on = (feed_reg != '0);
  assign out_empty = f.punch && empty_s;
  // anything that holds back the station as a whole
  assign stall = ret_s || feed_on || out_empty;

  // one character per paced slot; host output has priority over local input
  assign take_host = on && (seq_reg == ST_IDLE) && pace_ok && !stall && !host_busy_o &&
                     from_host && host_out_valid_i;
  assign take_card = on && (seq_reg == ST_IDLE) && pace_ok && !stall &&
                     card_pend_reg && !take_host;
  assign take_kbd = on && (seq_reg == ST_IDLE) && pace_ok && !stall && kbd_pend_reg &&
                    !take_host && !take_card;
  assign take_any = take_host || take_card || take_kbd || (pace_ok && seq_reg != ST_IDLE);
  assign pace_start = take_any;
  // codes are shared across devices here, so translation is identity
  assign ch = take_host ? host_out_data_i : (take_card ? card_char_reg : kbd_char_reg);
  assign card_wrap = (take_card || (skip_edge && f.rd) ||
                      (f.punch && (take_host || take_kbd))) && (ccol_reg == CARD_COLS - 7'h01);
  assign interval = card_active ? TIMER_W'(SLOW_CYC) : TIMER_W'(FAST_CYC);

  rate_pacer pacer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(pace_start),
    .interval_i(interval),
    .ready_o(pace_ok)
  );

  // pending local characters; a new strobe in the take cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kbd_pend_reg <= 1'b0;
      card_pend_reg <= 1'b0;
      kbd_char_reg <= '0;
      card_char_reg <= '0;
    end else if (ce_i) begin
      if (kbd_edge && f.kbd && !kbd_lock_o) begin
        kbd_pend_reg <= 1'b1;
        kbd_char_reg <= kbd_d2_reg;
      end else if (take_kbd) begin
        kbd_pend_reg <= 1'b0;
      end
      if (card_edge && f.rd) begin
        card_pend_reg <= 1'b1;
        card_char_reg <= card_d2_reg;
      end else if (take_card) begin
        card_pend_reg <= 1'b0;
      end
    end
  end

  // card column count and feed cycle after the last column
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ccol_reg <= '0;
      feed_reg <= '0;
    end else if (ce_i) begin
      if (card_wrap) begin
        ccol_reg <= '0;
        feed_reg <= TIMER_W'(FEED_CYC);
      end else begin
        if (take_card || (skip_edge && f.rd) || (f.punch && (take_host || take_kbd))) begin
          ccol_reg <= ccol_reg + 7'h01;
        end
        if (feed_on) begin
          feed_reg <= feed_reg - 23'h000001;
        end
      end
    end
  end

  // end-of-card line ending toward the printer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_reg <= ST_IDLE;
    end else if (ce_i) begin
      case (seq_reg)
        ST_IDLE: begin
          if (card_wrap && f.rd && f.print) begin
            seq_reg <= ST_CR;
          end
        end
        ST_CR: begin
          if (pace_ok) begin
            seq_reg <= ST_LF;
          end
        end
        ST_LF: begin
          if (pace_ok) begin
            seq_reg <= ST_IDLE;
          end
        end
        default: begin
          seq_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // device outputs: one strobe per character to each active device, except printer chars past the margin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prn_data_o <= '0;
      prn_strobe_o <= 1'b0;
      punch_data_o <= '0;
      punch_strobe_o <= 1'b0;
      host_in_data_o <= '0;
      host_in_valid_o <= 1'b0;
      host_out_ack_o <= 1'b0;
      pcol_reg <= '0;
    end else if (ce_i) begin
      prn_strobe_o <= 1'b0;
      punch_strobe_o <= 1'b0;
      host_in_valid_o <= 1'b0;
      host_out_ack_o <= take_host;
      if (pace_ok && seq_reg != ST_IDLE) begin
        prn_data_o <= (seq_reg == ST_CR) ? CODE_CR : CODE_LF;
        prn_strobe_o <= 1'b1;
        if (seq_reg == ST_CR) begin
          pcol_reg <= '0;
        end
      end else if (take_host || take_card || take_kbd) begin
        // line ends only when CR arrives, extra characters past the margin are dropped
        if (f.print || bidir) begin
          if (ch == CODE_CR) begin
            pcol_reg <= '0;
            prn_data_o <= ch;
            prn_strobe_o <= 1'b1;
          end else if (ch == CODE_LF) begin
            prn_data_o <= ch;
            prn_strobe_o <= 1'b1;
          end else if (pcol_reg < LINE_COLS) begin
            pcol_reg <= pcol_reg + 7'h01;
            prn_data_o <= ch;
            prn_strobe_o <= 1'b1;
          end
        end
        if (f.punch && !take_card) begin
          punch_data_o <= ch;
          punch_strobe_o <= 1'b1;
        end
        if (to_host && !take_host) begin
          host_in_data_o <= ch;
          host_in_valid_o <= 1'b1;
        end
      end
    end
  end

  // status pins and busy toward the host
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_busy_o <= 1'b1;
      kbd_lock_o <= 1'b1;
      alarm_o <= 1'b0;
      card_mode_o <= CARD_OFF;
    end else if (ce_i) begin
      host_busy_o <= stall || (seq_reg != ST_IDLE) || !from_host || take_host;
      kbd_lock_o <= !(f.print || bidir) || host_ready_busy_i ||
                    (f.punch && (punch_busy_s || empty_s));
      alarm_o <= out_empty;
      // reader and punch are never both decoded, so one select suffices
      card_mode_o <= f.rd ? CARD_READ : (f.punch ? CARD_PUNCH : CARD_OFF);
    end
  end

  // wishbone slave, ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      ctrl_reg <= CTRL_RST;
      count_reg <= '0;
    end else if (ce_i) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (take_host || take_card || take_kbd) begin
        count_reg <= count_reg + 32'h00000001;
      end
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= '0;
        if (wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
          ctrl_reg <= wb_dat_i[4:0];
        end
        if (!wb_we_i) begin
          case (wb_adr_i)
            REG_CTRL: wb_dat_o <= {27'h0, ctrl_reg};
            REG_STATUS: begin
              wb_dat_o[ST_BUSY_BIT] <= host_busy_o;
              wb_dat_o[ST_LOCK_BIT] <= kbd_lock_o;
              wb_dat_o[ST_ALARM_BIT] <= alarm_o;
              wb_dat_o[ST_FEED_BIT] <= feed_on;
              wb_dat_o[ST_CCOL_LSB +: 7] <= ccol_reg;
              wb_dat_o[ST_PCOL_LSB +: 7] <= pcol_reg;
              wb_dat_o[ST_MODE_LSB +: 2] <= seq_reg;
            end
            REG_COUNT: wb_dat_o <= count_reg;
            default: wb_dat_o <= '0;
          endcase
        end
      end
    end
  end
endmodule

// ### common/station_pkg.sv
package station_pkg;
  // clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int FAST_CPS = 40;
  localparam int SLOW_CPS = 20;
  localparam int FEED_MS = 250;
  // least spacing of characters, rounded up to whole cycles
  localparam int FAST_CYCLES = (CLK_HZ + FAST_CPS - 1) / FAST_CPS;
  localparam int SLOW_CYCLES = (CLK_HZ + SLOW_CPS - 1) / SLOW_CPS;
  localparam int FEED_CYCLES = (CLK_HZ / 1000) * FEED_MS;
  localparam int TIMER_W = 23;
  // character geometry
  localparam int CHAR_W = 8;
  localparam logic [6:0] CARD_COLS = 7'h50;
  localparam logic [6:0] LINE_COLS = 7'h50;
  localparam logic [CHAR_W-1:0] CODE_CR = 8'h0d;
  localparam logic [CHAR_W-1:0] CODE_LF = 8'h0a;
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  // control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EN_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  localparam int ST_ALARM_BIT = 2;
  localparam int ST_FEED_BIT = 3;
  localparam int ST_CCOL_LSB = 8;
  localparam int ST_PCOL_LSB = 16;
  localparam int ST_MODE_LSB = 24;
  // card unit select on card_mode_o
  localparam logic [1:0] CARD_OFF = 2'h0;
  localparam logic [1:0] CARD_READ = 2'h1;
  localparam logic [1:0] CARD_PUNCH = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CR = 2'b01,
    ST_LF = 2'b10
  } seq_t;

  // device functions of one operating mode
  typedef struct packed {
    logic rd;
    logic kbd;
    logic to_host;
    logic from_host;
    logic punch;
    logic print;
  } mode_t;

  function automatic mode_t decode_mode(input logic [3:0] m);
    mode_t f;
    f.rd = (m >= 4'h1) && (m <= 4'h3);
    f.kbd = (m >= 4'h4) && (m <= 4'h6);
    f.to_host = (m == 4'h1) || (m == 4'h3) || (m == 4'h6);
    f.from_host = (m >= 4'h7) && (m <= 4'h9);
    f.punch = (m == 4'h5) || (m == 4'h8) || (m == 4'h9);
    f.print = ((m >= 4'h2) && (m <= 4'h7)) || (m == 4'h9);
    return f;
  endfunction
endpackage

// ### logic/rate_pacer.sv
`timescale 1ns/1ps
// spacing timer: after each start, ready stays low for interval-1 cycles, so starts are interval cycles apart
module rate_pacer (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // pacing
  input wire logic start_i,
  input wire logic [station_pkg::TIMER_W-1:0] interval_i,
  output logic ready_o
);
  import station_pkg::*;

  logic [TIMER_W-1:0] count_reg;

  // countdown; ready is the counter at zero so a start costs no extra cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else if (ce_i) begin
      if (start_i) begin
        count_reg <= interval_i - 23'h000001;
      end else if (count_reg != '0) begin
        count_reg <= count_reg - 23'h000001;
      end
    end
  end

  assign ready_o = (count_reg == '0);
endmodule

// ### testbench/station_assertions.sv
`timescale 1ns/1ps
// pin-level checks of the station; ce_i is only lowered while the station is quiet
module station_assertions #(
  parameter int FAST_CYC = station_pkg::FAST_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // host channel
  input wire logic [station_pkg::CHAR_W-1:0] host_out_data_i,
  input wire logic host_out_valid_i,
  input wire logic host_out_ack_o,
  input wire logic host_busy_o,
  input wire logic host_in_valid_o,
  input wire logic host_ready_busy_i,
  // station devices
  input wire logic kbd_lock_o,
  input wire logic [station_pkg::CHAR_W-1:0] prn_data_o,
  input wire logic prn_strobe_o,
  input wire logic prn_return_i,
  input wire logic [station_pkg::CHAR_W-1:0] punch_data_o,
  input wire logic punch_strobe_o,
  input wire logic [1:0] card_mode_o,
  input wire logic alarm_o
);
  import station_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int gap;
  // cycles since the last take; starts saturated so the first take passes
  always_ff @(posedge clk_i) begin
    if (rst_i) gap <= FAST_CYC;
    else if (host_out_ack_o) gap <= 0;
    else if (gap < FAST_CYC) gap <= gap + 1;
  end
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than a cycle");
  a_take_cause: assert property (
    host_out_ack_o |-> $past(host_out_valid_i && !host_busy_o)) else $error("take without offer");
  a_take_busy: assert property (host_out_ack_o |-> host_busy_o)
    else $error("no busy after take");
  a_take_paced: assert property (host_out_ack_o |-> gap >= FAST_CYC - 1)
    else $error("takes too close");
  a_print_copy: assert property (
    host_out_ack_o && prn_strobe_o |-> prn_data_o == $past(host_out_data_i))
    else $error("printer char altered");
  a_punch_copy: assert property (
    host_out_ack_o && punch_strobe_o |-> punch_data_o == $past(host_out_data_i))
    else $error("punch char altered");
  a_return_busy: assert property (prn_return_i [*4] |-> host_busy_o)
    else $error("no busy on return");
  a_lock_host: assert property (host_ready_busy_i [*3] |-> kbd_lock_o)
    else $error("keyboard not locked");
  a_alarm_mode: assert property ($rose(alarm_o) |-> card_mode_o == CARD_PUNCH)
    else $error("alarm outside punch");
  a_alarm_busy: assert property (alarm_o [*2] |-> host_busy_o)
    else $error("alarm without busy");
  a_card_legal: assert property (card_mode_o != 2'h3)
    else $error("card unit both ways");
  a_in_spaced: assert property (host_in_valid_o |=> !host_in_valid_o [*8])
    else $error("input chars too close");
  c_print: cover property (host_out_ack_o && prn_strobe_o);
  c_punch: cover property (host_out_ack_o && punch_strobe_o);
  c_input: cover property (host_in_valid_o);
  c_alarm: cover property (alarm_o);
endmodule

bind station_control station_assertions #(.FAST_CYC(FAST_CYC)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .host_out_data_i(host_out_data_i),
  .host_out_valid_i(host_out_valid_i), .host_out_ack_o(host_out_ack_o),
  .host_busy_o(host_busy_o), .host_in_valid_o(host_in_valid_o),
  .host_ready_busy_i(host_ready_busy_i), .kbd_lock_o(kbd_lock_o),
  .prn_data_o(prn_data_o), .prn_strobe_o(prn_strobe_o), .prn_return_i(prn_return_i),
  .punch_data_o(punch_data_o), .punch_strobe_o(punch_strobe_o),
  .card_mode_o(card_mode_o), .alarm_o(alarm_o));

// ### testbench/host_model.sv
`timescale 1ns/1ps
// host channel: offers queued output chars, collects chars sent to it
module host_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // station side
  input wire logic busy_i,
  input wire logic ack_i,
  input wire logic [station_pkg::CHAR_W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic [station_pkg::CHAR_W-1:0] data_o,
  output logic valid_o,
  output logic busy_o
);
  import station_pkg::*;
  logic [CHAR_W-1:0] tx[$];
  logic [CHAR_W-1:0] rx[$];
  logic busy_req = 1'b0;
  assign busy_o = busy_req;
  initial begin
    data_o = 8'h00;
    valid_o = 1'b0;
  end
  // one whole char per offer; a released bus shows the inverse, not stale data
  always @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
    end else if (valid_o && ack_i) begin
      valid_o <= 1'b0;
      data_o <= ~data_o;
    end else if (!valid_o && tx.size() > 0 && !busy_i) begin
      valid_o <= 1'b1;
      data_o <= tx.pop_front();
    end
  end
  // chars for the host
  always @(posedge clk_i) if (in_valid_i) rx.push_back(in_data_i);
endmodule

// ### testbench/station_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) check(g, e)
module station_control_tb_top;
  import station_pkg::*;
  logic clk_i, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, h_ack, h_busy, in_valid, h_valid, h_rb, kbd_lock_o;
  logic [7:0] h_data, in_data, prn_data, pun_data, kbd_d = 8'h0, card_d = 8'h0;
  logic kbd_s = 0, card_s = 0, prn_ret = 0, empty = 0, prn_s, pun_s, alarm_o;
  logic skip = 0, pbusy = 0;
  logic [3:0] sel = 4'hf;
  logic [1:0] card_mode_o;
  int n_errors = 0, num_checks = 0, prn_n = 0, pun_n = 0;
  logic [7:0] prn_d, pun_d;
  // short counts keep the run brief
  station_control #(.FAST_CYC(20), .SLOW_CYC(40), .FEED_CYC(100)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .host_out_data_i(h_data), .host_out_valid_i(h_valid),
    .host_out_ack_o(h_ack), .host_busy_o(h_busy), .host_in_data_o(in_data),
    .host_in_valid_o(in_valid), .host_ready_busy_i(h_rb), .kbd_data_i(kbd_d),
    .kbd_strobe_i(kbd_s), .kbd_lock_o(kbd_lock_o), .prn_data_o(prn_data),
    .prn_strobe_o(prn_s), .prn_return_i(prn_ret), .card_data_i(card_d),
    .card_strobe_i(card_s), .card_skip_i(skip), .card_punch_busy_i(pbusy),
    .card_empty_i(empty), .punch_data_o(pun_data), .punch_strobe_o(pun_s),
    .card_mode_o(card_mode_o), .alarm_o(alarm_o));
  host_model host (.clk_i(clk_i), .rst_i(rst_i), .busy_i(h_busy), .ack_i(h_ack),
    .in_data_i(in_data), .in_valid_i(in_valid), .data_o(h_data), .valid_o(h_valid),
    .busy_o(h_rb));
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  // device strobes are one-cycle pulses, so count them on every edge
  always @(posedge clk_i) begin
    if (prn_s) begin prn_n++; prn_d = prn_data; end
    if (pun_s) begin pun_n++; pun_d = pun_data; end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // classic cycle; read data taken at the ack edge only
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    sel <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task wait_prn(input int n);
    for (int i = 0; i < 400 && prn_n < n; i++) @(posedge clk_i);
  endtask
  task t_reset;
    `CHK(h_busy, 1'b1);
    `CHK(kbd_lock_o, 1'b1);
    `CHK(card_mode_o, CARD_OFF);
    @(posedge clk_i) rst_i <= 0;
    wb(0, REG_CTRL, 32'h0);
    `CHK(rdat, 32'h0);
    wb(0, 4'hc, 32'h0);
    `CHK(rdat, 32'h0);
    // a control write without the low byte lane must leave the station idle
    wb(1, REG_CTRL, 32'h17, 4'he);
    wb(0, REG_CTRL, 32'h0);
    `CHK(rdat, 32'h0);
    $display("test reset done");
  endtask
  task t_print;
    wb(1, REG_CTRL, 32'h17);
    host.tx.push_back(8'h41);
    host.tx.push_back(CODE_CR);
    host.tx.push_back(CODE_LF);
    wait_prn(3);
    `CHK(prn_n, 3);
    `CHK(prn_d, CODE_LF);
    `CHK(pun_n, 0);
    `CHK(card_mode_o, CARD_OFF);
    prn_ret <= 1;
    host.tx.push_back(8'h5a);
    repeat (60) @(posedge clk_i);
    `CHK(prn_n, 3);
    prn_ret <= 0;
    wait_prn(4);
    `CHK(prn_d, 8'h5a);
    $display("test print done");
  endtask
  task t_punch;
    wb(1, REG_CTRL, 32'h19);
    host.tx.push_back(8'h42);
    for (int i = 0; i < 400 && pun_n < 1; i++) @(posedge clk_i);
    `CHK(pun_d, 8'h42);
    `CHK(prn_d, 8'h42);
    `CHK(card_mode_o, CARD_PUNCH);
    empty <= 1;
    repeat (6) @(posedge clk_i);
    `CHK(alarm_o, 1'b1);
    `CHK(h_busy, 1'b1);
    empty <= 0;
    pbusy <= 1;
    repeat (6) @(posedge clk_i);
    `CHK(kbd_lock_o, 1'b1);
    pbusy <= 0;
    repeat (6) @(posedge clk_i);
    `CHK(kbd_lock_o, 1'b0);
    `CHK(alarm_o, 1'b0);
    $display("test punch done");
  endtask
  task t_kbd;
    wb(1, REG_CTRL, 32'h16);
    for (int i = 0; i < 400 && kbd_lock_o !== 1'b0; i++) @(posedge clk_i);
    kbd_d <= 8'h4b;
    kbd_s <= 1;
    for (int i = 0; i < 400 && host.rx.size() < 1; i++) @(posedge clk_i);
    // one more edge so the printer capture of the same slot has settled
    @(posedge clk_i);
    kbd_s <= 0;
    `CHK(host.rx[0], 8'h4b);
    `CHK(prn_d, 8'h4b);
    host.tx.push_back(8'h52);
    wait_prn(prn_n + 1);
    `CHK(prn_d, 8'h52);
    host.busy_req <= 1;
    repeat (4) @(posedge clk_i);
    `CHK(kbd_lock_o, 1'b1);
    host.busy_req <= 0;
    $display("test keyboard done");
  endtask
  task t_card;
    int p;
    wb(1, REG_CTRL, 32'h11);
    p = prn_n;
    card_d <= 8'h43;
    card_s <= 1;
    for (int i = 0; i < 400 && host.rx.size() < 2; i++) @(posedge clk_i);
    card_s <= 0;
    `CHK(host.rx[1], 8'h43);
    `CHK(card_mode_o, CARD_READ);
    `CHK(prn_n, p);
    skip <= 1;
    repeat (4) @(posedge clk_i);
    skip <= 0;
    repeat (4) @(posedge clk_i);
    // a frozen station must not see the strobe until the enable returns
    ce_i <= 0;
    card_d <= 8'h44;
    card_s <= 1;
    repeat (10) @(posedge clk_i);
    `CHK(host.rx.size(), 2);
    ce_i <= 1;
    for (int i = 0; i < 400 && host.rx.size() < 3; i++) @(posedge clk_i);
    card_s <= 0;
    `CHK(host.rx[2], 8'h44);
    wb(0, REG_STATUS, 32'h0);
    `CHK(rdat[ST_CCOL_LSB +: 7], 7'h04);
    $display("test card done");
  endtask
  // the rest of the card (76 columns) skipped: feed cycle plus inserted line ending
  task t_wrap;
    int p;
    wb(1, REG_CTRL, 32'h13);
    p = prn_n;
    for (int i = 0; i < 76; i++) begin
      skip <= 1;
      repeat (4) @(posedge clk_i);
      skip <= 0;
      repeat (4) @(posedge clk_i);
    end
    wb(0, REG_STATUS, 32'h0);
    `CHK(rdat[ST_FEED_BIT], 1'b1);
    `CHK(rdat[ST_CCOL_LSB +: 7], 7'h00);
    wait_prn(p + 1);
    `CHK(prn_d, CODE_CR);
    wait_prn(p + 2);
    `CHK(prn_d, CODE_LF);
    `CHK(prn_n, p + 2);
    repeat (120) @(posedge clk_i);
    wb(0, REG_STATUS, 32'h0);
    `CHK(rdat[ST_FEED_BIT], 1'b0);
    $display("test wrap done");
  endtask
  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    t_reset;
    t_print;
    t_punch;
    t_kbd;
    t_card;
    t_wrap;
    final_report;
  end
endmodule
